// *** hdl/dpm_defs.vh ***
// constants for the ds1 primary rate frame and channel mapper
`ifndef DPM_DEFS_VH
`define DPM_DEFS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DPM_REG_CTRL     8'h00
`define DPM_REG_ALLOC    8'h04
`define DPM_REG_SIXMAP   8'h08
`define DPM_REG_IDLE     8'h0C
`define DPM_REG_STATUS   8'h10
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define DPM_CTRL_ESF     0
`define DPM_CTRL_B8ZS    1
`define DPM_CTRL_YELLOW  2
`define DPM_CTRL_DUAL    3
`define DPM_CTRL_HAS_D   4
`define DPM_CTRL_FULL    5
`define DPM_CTRL_FCALL   6
`define DPM_CTRL_RST     8'h11
// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define DPM_ALLOC_RST    24'h000000
`define DPM_SIX_RST      8'h00
`define DPM_IDLE_RST     8'hFF
`define DPM_IDLE_ONES    8'h7F
`define DPM_YEL_WORD     16'hFF00
`define DPM_CRC_POLY     6'h03
`define DPM_FT_PAT       6'h2A
`define DPM_FS_PAT       6'h0E
`define DPM_FPS_PAT      6'h0B
// ----------------------------------------------------------------
// frame geometry and timing
// ----------------------------------------------------------------
`define DPM_SLOTS        24
`define DPM_FRAME_BITS   193
`define DPM_ESF_FRAMES   24
`define DPM_D4_FRAMES    12
`define DPM_ESF_LAST     5'd23
`define DPM_D4_LAST      5'd11
`define DPM_MAX_IFACE    28
`define DPM_MAX_BEARER   671
`define DPM_FRAME_NS     125000
`define DPM_YEL_MS       335
`define DPM_YEL_FRAMES   ((`DPM_YEL_MS * 1000000) / `DPM_FRAME_NS)
`define DPM_FT_RUN       6
`endif

// *** hdl/dpm_mapper.v ***
// ds1 primary rate framer and time-slot channel mapper with apb registers
`timescale 1ns/1ps
`include "dpm_defs.vh"

// Function
// - frame is F bit plus 24 octets
// - no robbed bits, octets pass whole
// - esf F bits: framing, crc6, data link
// - data link yellow, otherwise all ones
// - break stable ft emulation in d4 payload
// - stop spurious bit-two-zero yellow in d4
// - esf selected by default after reset
// - slots map to d, b, six, full
// - d channel fixed in slot 24
// - single facility six groups 1-18 only
// - group 19-24 and full need no d
// - d domain limits 28 interfaces, 671 slots (not counted here)
// - ami: no zero octet in d/b/six
// - ami: no zero octet in full channel
// - restricted d channel uses inverted hdlc
// - clear channel only with b8zs coding
// - idle code in unassigned or unallocated slots
// - customer idle code has seven ones
// - idle code never inverted
// - receive idle status from provisioning only
// - esf yellow is eight ones, eight zeros
// - invert hdlc on tx, restore on rx
module dpm_mapper #(
  parameter YEL_FRAMES = `DPM_YEL_FRAMES, // d4 bit-two guard, in frames
  parameter FT_RUN     = `DPM_FT_RUN      // ft frames before guard acts
) (
  input  wire        CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        LINE_BIT_EN,
  input  wire [7:0]  TX_OCTET,
  output reg  [4:0]  TX_SLOT,
  output reg         TX_TAKE,
  output reg         TX_DATA,
  input  wire        RX_DATA,
  input  wire        RX_SYNC,
  output reg  [7:0]  RX_OCTET,
  output reg  [4:0]  RX_SLOT,
  output reg         RX_VALID,
  output reg         RX_IDLE
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0]  ctrl;        // mode and arrangement bits
  reg  [23:0] alloc;       // per-slot channel allocated to a call
  reg  [7:0]  sixmap;      // [3:0] group assigned, [7:4] group in call
  reg  [7:0]  idle_code;   // customer idle code, low seven bits always ones
  reg  [7:0]  tx_pos;      // bit position in frame, 0 is the F bit
  reg  [4:0]  tx_frm;      // frame number in superframe, from 0
  reg  [6:0]  tx_sh;       // remaining bits of the current octet
  reg  [5:0]  crc;         // running crc of this superframe
  reg  [5:0]  crc_last;    // crc of previous superframe, sent now
  reg  [3:0]  yel_idx;     // position in the yellow word
  reg         b2_seen;     // some slot had bit two set this frame
  reg  [11:0] b2_run;      // frames in a row with bit two all zero
  reg  [7:0]  ft_prev [0:23]; // octet of last ft frame per slot
  reg  [7:0]  ft_acc  [0:23]; // bits that alternated every ft frame
  reg  [3:0]  ft_cnt  [0:23]; // ft frames the alternation has lasted
  reg  [7:0]  rx_pos;      // receive bit position
  reg  [7:0]  rx_sh;       // receive shifter
  integer     i;

  // ----------------------------------------------------------------
  // arrangement checks
  // ----------------------------------------------------------------
  wire esf      = ctrl[`DPM_CTRL_ESF];
  wire restr    = ~ctrl[`DPM_CTRL_B8ZS];       // ami means restricted
  wire yellow   = ctrl[`DPM_CTRL_YELLOW];
  wire dual     = ctrl[`DPM_CTRL_DUAL];
  wire has_d    = ctrl[`DPM_CTRL_HAS_D];
  // this block serves one facility and one d channel; the limit of 28
  // facilities and 671 bearer slots per d channel is a provisioning
  // bound that software keeps, nothing here can count it
  // group 19-24 only on a dual facility without the d channel
  wire g4_ok    = dual & ~has_d;
  wire [3:0] six_eff = {sixmap[3] & g4_ok, sixmap[2:0]};
  // full channel only where no d channel sits on this facility
  wire full_eff = ctrl[`DPM_CTRL_FULL] & g4_ok;
  wire map_err  = (sixmap[3] & ~g4_ok) |
                  (ctrl[`DPM_CTRL_FULL] & ~g4_ok);

  // ----------------------------------------------------------------
  // transmit octet build
  // ----------------------------------------------------------------
  // slot index of the octet being loaded, slot n uses index n-1
  wire [4:0] ld_idx = tx_pos[7:3];
  // the octet is sampled on the enable that sends its first bit, so the
  // user side must present it while tx_slot names that slot
  wire       ld_now = LINE_BIT_EN & (tx_pos[2:0] == 3'h1);
  wire       ft_frm = ~tx_frm[0];              // odd frames carry ft
  wire [1:0] grp    = (ld_idx < 5'd6)  ? 2'd0 :
                      (ld_idx < 5'd12) ? 2'd1 :
                      (ld_idx < 5'd18) ? 2'd2 : 2'd3;
  wire       is_d   = has_d & (ld_idx == 5'd23);
  reg        active;
  reg  [7:0] cand;
  reg  [7:0] ft_alt;
  reg  [7:0] out_oct;
  reg        ft_fix;

  // picks idle or user data and applies the line restrictions
  always @* begin
    ft_alt = 8'h00;
    ft_fix = 1'b0;
    if (is_d)
      active = 1'b1;
    else if (full_eff)
      active = ctrl[`DPM_CTRL_FCALL];
    else if (six_eff[grp])
      active = sixmap[4 + grp];
    else
      active = alloc[ld_idx];
    // whole octet passes, nothing robbed for signalling
    cand = (is_d & restr) ? ~TX_OCTET : TX_OCTET;
    if (!active) begin
      out_oct = idle_code;                     // not inverted
    end else begin
      out_oct = cand;
      if (!esf && ft_frm) begin
        // freeze bits that kept alternating on ft frames
        ft_alt = (ft_cnt[ld_idx] == 4'h0) ? (cand ^ ft_prev[ld_idx]) :
                 ((cand ^ ft_prev[ld_idx]) & ft_acc[ld_idx]);
        if (ft_cnt[ld_idx] >= FT_RUN[3:0] - 4'h1 && ft_alt != 8'h00) begin
          out_oct = cand ^ ft_alt;
          ft_fix  = 1'b1;
        end
      end
      // last slot of a frame with bit two zero everywhere
      if (!esf && !yellow && ld_idx == 5'd23 && !b2_seen &&
          b2_run >= YEL_FRAMES[11:0] - 12'h001)
        out_oct[6] = 1'b1;
      // d4 yellow clears bit two before suppression looks at the octet,
      // so under ami a 0x40 octet still leaves as a non-zero pattern
      if (!esf && yellow)
        out_oct[6] = 1'b0;
      // zero suppression: last bit set, any channel type
      if (restr && out_oct == 8'h00)
        out_oct = 8'h01;
    end
    // d4 yellow forces bit two to zero in all 24 slots
    if (!esf && yellow)
      out_oct[6] = 1'b0;
  end

  // ----------------------------------------------------------------
  // framing bit select
  // ----------------------------------------------------------------
  reg        fbit;
  wire [2:0] sub = tx_frm[4:2];                // four-frame group index in esf, 0..5
  // pattern words padded to eight bits so an index left over from the
  // other framing mode, during the frame of a switch, stays in range
  wire [15:0] yel_word = `DPM_YEL_WORD;         // yellow, sent msb first
  wire [7:0]  fps_word = {2'b00, `DPM_FPS_PAT}; // esf alignment pattern
  wire [7:0]  ft_word  = {2'b00, `DPM_FT_PAT};  // d4 terminal framing
  wire [7:0]  fs_word  = {2'b00, `DPM_FS_PAT};  // d4 superframe framing
  always @* begin
    fbit = 1'b1;
    if (esf) begin
      case (tx_frm[1:0])
        2'd0, 2'd2: begin                      // data link frames
          // yellow word otherwise continuous ones
          fbit = yellow ? yel_word[4'hF - yel_idx] : 1'b1;
        end
        2'd1: begin                            // crc bits c1..c6
          fbit = crc_last[3'd5 - sub];
        end
        2'd3: begin                            // alignment pattern
          fbit = fps_word[3'd5 - sub];
        end
        default: fbit = 1'b1;
      endcase
    end else begin
      // ft on odd frames, fs on even frames of the 12-frame superframe
      if (ft_frm)
        fbit = ft_word[3'd5 - tx_frm[3:1]];
      else
        fbit = fs_word[3'd5 - tx_frm[3:1]];
    end
  end

  wire       tx_bit = (tx_pos == 8'h00) ? fbit :
                      ld_now ? out_oct[7] : tx_sh[6];
  // crc runs over the whole superframe with F bits taken as ones
  wire       crc_in = (tx_pos == 8'h00) ? 1'b1 : tx_bit;
  wire       crc_fb = crc[5] ^ crc_in;
  wire [5:0] crc_nx = {crc[4:0], 1'b0} ^ (crc_fb ? `DPM_CRC_POLY : 6'h00);
  // superframe length follows the framing mode; a mode switch moves the wrap
  // at the next frame boundary, but the d4 payload rules change from the next octet
  wire [4:0] frm_top = esf ? `DPM_ESF_LAST : `DPM_D4_LAST;
  wire       last_b = (tx_pos == `DPM_FRAME_BITS - 1);

  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  // one bit per line enable, loop timed from the received clock
  always @(posedge CLK) begin
    if (RST) begin
      tx_pos   <= 8'h00;
      tx_frm   <= 5'h00;
      tx_sh    <= 7'h7F;
      TX_DATA  <= 1'b1;
      TX_SLOT  <= 5'h01;
      TX_TAKE  <= 1'b0;
      crc      <= 6'h00;
      crc_last <= 6'h00;
      yel_idx  <= 4'h0;
      b2_seen  <= 1'b0;
      b2_run   <= 12'h000;
      for (i = 0; i < `DPM_SLOTS; i = i + 1) begin
        ft_prev[i] <= 8'h00;
        ft_acc[i]  <= 8'h00;
        ft_cnt[i]  <= 4'h0;
      end
    end else begin
      TX_TAKE <= ld_now;
      if (LINE_BIT_EN) begin
        TX_DATA <= tx_bit;
        tx_pos  <= last_b ? 8'h00 : tx_pos + 8'h01; // 193 bits
        if (ld_now) begin
          tx_sh   <= out_oct[6:0];
          TX_SLOT <= (ld_idx == 5'd23) ? 5'h01 : ld_idx + 5'h02;
          b2_seen <= b2_seen | out_oct[6];
          if (!esf && ft_frm) begin
            ft_prev[ld_idx] <= out_oct;
            ft_acc[ld_idx]  <= ft_alt;
            if (ft_fix || ft_alt == 8'h00)
              ft_cnt[ld_idx] <= 4'h0;
            else if (ft_cnt[ld_idx] != 4'hF)
              ft_cnt[ld_idx] <= ft_cnt[ld_idx] + 4'h1;
          end
        end else begin
          tx_sh <= {tx_sh[5:0], 1'b1};
        end
        // data link bit consumed: advance the yellow word
        if (esf && tx_pos == 8'h00 && !tx_frm[0])
          yel_idx <= yel_idx + 4'h1;
        if (tx_pos == 8'h00) begin
          b2_seen <= 1'b0;
        end
        if (last_b) begin
          // frame boundary: bit-two run and superframe count
          if (b2_seen || esf)
            b2_run <= 12'h000;
          else if (b2_run != 12'hFFF)
            b2_run <= b2_run + 12'h001;
          if (tx_frm >= frm_top) begin
            tx_frm   <= 5'h00;
            crc_last <= crc_nx;
            crc      <= 6'h00;
          end else begin
            tx_frm <= tx_frm + 5'h01;
            crc    <= crc_nx;
          end
        end else begin
          crc <= crc_nx;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive slot demapper
  // ----------------------------------------------------------------
  // rx_sync marks the F bit; idle comes from provisioning only
  wire [4:0] rx_idx = rx_pos[7:3] - 5'h01;
  wire       rx_end = (rx_pos[2:0] == 3'h0) && (rx_pos != 8'h00);
  wire [7:0] rx_byte = {rx_sh[6:0], RX_DATA};
  wire       rx_d   = has_d & (rx_idx == 5'd23);
  wire [1:0] rgrp   = (rx_idx < 5'd6)  ? 2'd0 :
                      (rx_idx < 5'd12) ? 2'd1 :
                      (rx_idx < 5'd18) ? 2'd2 : 2'd3;
  // receive activity uses the same provisioning as transmit, so both
  // directions agree on which slots are idle
  wire       rx_act = rx_d | (full_eff ? ctrl[`DPM_CTRL_FCALL] :
                      six_eff[rgrp] ? sixmap[4 + rgrp] : alloc[rx_idx]);

  // collects eight bits per slot and hands the octet out
  always @(posedge CLK) begin
    if (RST) begin
      rx_pos   <= 8'h00;
      rx_sh    <= 8'h00;
      RX_OCTET <= 8'h00;
      RX_SLOT  <= 5'h00;
      RX_VALID <= 1'b0;
      RX_IDLE  <= 1'b1;
    end else begin
      RX_VALID <= 1'b0;
      if (LINE_BIT_EN) begin
        rx_sh <= rx_byte;
        if (RX_SYNC || rx_pos == `DPM_FRAME_BITS - 1)
          rx_pos <= RX_SYNC ? 8'h01 : 8'h00;
        else
          rx_pos <= rx_pos + 8'h01;
        if (rx_end && !RX_SYNC) begin
          RX_VALID <= 1'b1;
          RX_SLOT  <= rx_idx + 5'h01;
          // restore inverted hdlc on the restricted d channel
          RX_OCTET <= (rx_d & restr) ? ~rx_byte : rx_byte;
          RX_IDLE  <= ~rx_act;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state keeps prdata a clean flip-flop output
  // status writes are dropped quietly; unmapped places answer with a
  // slave error and read as zero
  wire acc  = PSEL & PENABLE & PREADY;
  wire wr   = acc & PWRITE;
  wire hit  = (PADDR == `DPM_REG_CTRL) | (PADDR == `DPM_REG_ALLOC) |
              (PADDR == `DPM_REG_SIXMAP) | (PADDR == `DPM_REG_IDLE) |
              (PADDR == `DPM_REG_STATUS);
  reg [31:0] rd_mux;

  // read data select; unmapped reads zero
  always @*
    case (PADDR)
      `DPM_REG_CTRL:   rd_mux = {25'h0, ctrl[6:0]};
      `DPM_REG_ALLOC:  rd_mux = {8'h00, alloc};
      `DPM_REG_SIXMAP: rd_mux = {24'h0, sixmap};
      `DPM_REG_IDLE:   rd_mux = {24'h0, idle_code};
      `DPM_REG_STATUS: rd_mux = {16'h0, 2'h0, crc_last, 2'h0,
                                 map_err, tx_frm};
      default:         rd_mux = 32'h0;
    endcase

  // register writes happen only at the completing edge
  always @(posedge CLK) begin
    if (RST) begin
      ctrl      <= `DPM_CTRL_RST;              // esf preferred
      alloc     <= `DPM_ALLOC_RST;
      sixmap    <= `DPM_SIX_RST;
      idle_code <= `DPM_IDLE_RST;
      PREADY    <= 1'b0;
      PRDATA    <= 32'h0;
      PSLVERR   <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PRDATA  <= rd_mux;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit;
      if (wr) begin
        case (PADDR)
          `DPM_REG_CTRL:   ctrl   <= {1'b0, PWDATA[6:0]};
          `DPM_REG_ALLOC:  alloc  <= PWDATA[23:0];
          `DPM_REG_SIXMAP: sixmap <= PWDATA[7:0];
          // low seven bits forced: at least 7 contiguous ones
          `DPM_REG_IDLE:   idle_code <= PWDATA[7:0] | `DPM_IDLE_ONES;
          default: ;
        endcase
      end
    end
  end

endmodule

// *** sim/dpm_line_model.sv ***
// network line termination model: bit timing, receive stream, tx capture
`timescale 1ns/1ps
module dpm_line_model #(
  parameter DIV = 3  // clocks per line bit; larger values act slower
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic         TX_DATA,
  output logic              LINE_BIT_EN,
  output logic              RX_DATA,
  output logic              RX_SYNC,
  output logic [15:0]       nfr,
  output logic [192:0]      frm,
  output logic [23:0]       fsf,
  output logic [23:0]       fh
);
  localparam [7:0] NET_IDLE = 8'hF0; // network idle, four ones
  int           d;    // bit clock divider
  logic [7:0]   p;    // position of the coming line bit
  logic [7:0]   lp;   // position of the bit captured now
  logic         run;  // first enable seen
  logic [191:0] cur;  // tx bits of the frame in progress
  logic [4:0]   lf;   // frame index within a superframe

  // line bits loop back: tx launched after one enable is taken at the next
  always @(posedge CLK) begin
    if (RST) begin
      d <= 0;
      LINE_BIT_EN <= 0;
      p <= 0;
      lp <= 0;
      run <= 0;
      lf <= 0;
      nfr <= 0;
      RX_DATA <= 1;
      RX_SYNC <= 0;
    end else begin
      d <= (d == DIV - 1) ? 0 : d + 1;
      LINE_BIT_EN <= (d == DIV - 1);
      if (d == DIV - 1) begin // f bit then 24 octets, msb first
        RX_SYNC <= (p == 0);
        RX_DATA <= (p == 0) ? 1'b1 : NET_IDLE[7 - (p - 1) % 8];
      end
      if (LINE_BIT_EN) begin
        p <= (p == 192) ? 8'h00 : p + 8'h01;
        lp <= p;
        run <= 1;
        if (run) begin
          cur <= {cur[190:0], TX_DATA};
          if (lp == 192) begin
            frm <= {cur, TX_DATA};
            fsf[lf] <= cur[191];
            fh <= {fh[22:0], cur[191]};
            lf <= (lf == 23) ? 5'h00 : lf + 5'h01;
            nfr <= nfr + 16'h0001;
          end
        end
      end
    end
  end
endmodule

// *** sim/dpm_mapper_chk.sv ***
// assertion checker for the ds1 frame and channel mapper
`timescale 1ns/1ps
module dpm_mapper_chk (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       LINE_BIT_EN,
  input wire logic [4:0] TX_SLOT,
  input wire logic       TX_TAKE,
  input wire logic       TX_DATA,
  input wire logic [4:0] RX_SLOT,
  input wire logic       RX_VALID
);
  // ----------------------------------------------------------------
  // one clock domain, so one default clocking and disable
  // ----------------------------------------------------------------
  default clocking dpm_cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // apb answer lands in the second access cycle, never later
  chk_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready not given in second access cycle");
  chk_ready_access: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL))
    else $error("ready outside an access phase");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("slave error without ready");
  // slot take follows a line bit, slot number steps 1..24
  chk_take_bit: assert property (TX_TAKE |-> $past(LINE_BIT_EN))
    else $error("octet take without line bit");
  chk_take_slot: assert property (TX_TAKE |-> TX_SLOT == $past(TX_SLOT, 2) % 24 + 1)
    else $error("slot number did not step");
  chk_take_pulse: assert property (TX_TAKE |=> !TX_TAKE)
    else $error("take longer than one cycle");
  // line bit holds between line bit enables
  chk_tx_hold: assert property (!$past(LINE_BIT_EN) |-> $stable(TX_DATA))
    else $error("line bit changed without enable");
  chk_rx_slot: assert property (RX_VALID |-> RX_SLOT >= 1 && RX_SLOT <= 24)
    else $error("received slot out of range");
  chk_rx_pulse: assert property (RX_VALID |=> !RX_VALID)
    else $error("receive valid longer than one cycle");
endmodule

bind dpm_mapper dpm_mapper_chk dpm_mapper_chk_inst (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .LINE_BIT_EN(LINE_BIT_EN), .TX_SLOT(TX_SLOT), .TX_TAKE(TX_TAKE),
  .TX_DATA(TX_DATA), .RX_SLOT(RX_SLOT), .RX_VALID(RX_VALID));

// *** sim/dpm_mapper_tb_top.sv ***
// self-checking testbench for the ds1 frame and channel mapper
`timescale 1ns/1ps
`include "dpm_defs.vh"
module dpm_mapper_tb_top;
  logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        LINE_BIT_EN, TX_TAKE, TX_DATA, RX_DATA, RX_SYNC;
  logic        RX_VALID, RX_IDLE;
  logic [7:0]  PADDR, TX_OCTET, RX_OCTET;
  logic [31:0] PWDATA, PRDATA;
  logic [4:0]  TX_SLOT, RX_SLOT;
  logic [15:0] nfr;
  logic [192:0] frm;
  logic [23:0] fsf, fh;
  logic [7:0]  rxo [1:24];  // last octet per received slot
  logic        rxi [1:24];  // last idle flag per received slot
  int          n_errors, checked, i, z, mx;
  logic        b2;          // some slot of the frame had bit two set

  // short yellow and ft counts keep the run brief
  dpm_mapper #(.YEL_FRAMES(4), .FT_RUN(2)) dpm_mapper_inst (.CLK(CLK),
    .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .LINE_BIT_EN(LINE_BIT_EN), .TX_OCTET(TX_OCTET),
    .TX_SLOT(TX_SLOT), .TX_TAKE(TX_TAKE), .TX_DATA(TX_DATA),
    .RX_DATA(RX_DATA), .RX_SYNC(RX_SYNC), .RX_OCTET(RX_OCTET),
    .RX_SLOT(RX_SLOT), .RX_VALID(RX_VALID), .RX_IDLE(RX_IDLE));
  dpm_line_model dpm_line_model_inst (.CLK(CLK), .RST(RST),
    .TX_DATA(TX_DATA), .LINE_BIT_EN(LINE_BIT_EN), .RX_DATA(RX_DATA),
    .RX_SYNC(RX_SYNC), .nfr(nfr), .frm(frm), .fsf(fsf), .fh(fh));

  initial begin
    CLK = 0;
    forever #20 CLK = ~CLK;
  end

  // keep what each receive slot delivered last
  always @(posedge CLK) begin
    if (RX_VALID) begin
      rxo[RX_SLOT] <= RX_OCTET;
      rxi[RX_SLOT] <= RX_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int k;
    @(posedge CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    if (k >= 50) begin
      check("apb ready", 1, 0);
      complete_run;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, exp,
                     input logic experr);
    logic [31:0] r;
    logic        e;
    apb(0, a, 0, r, e);
    check("read data", exp, r & m);
    check("slave error", experr, e);
  endtask

  // wait for k whole frames captured from the line
  task automatic frames(input int k);
    int          t;
    logic [15:0] n0;
    n0 = nfr;
    t = 0;
    while (nfr < n0 + k && t < 1000 * k) begin
      @(posedge CLK);
      t++;
    end
    if (t >= 1000 * k) begin
      check("frame wait", 1, 0);
      complete_run;
    end
  endtask

  function automatic logic [7:0] slot(input int n);
    return frm[191 - 8 * (n - 1) -: 8];
  endfunction

  // d4 f bits may start at any frame of the superframe
  function automatic logic is_rot(input logic [11:0] v, w);
    logic ok;
    ok = 0;
    for (int r = 0; r < 12; r++)
      if ((((w << r) | (w >> (12 - r))) & 12'hFFF) == v) ok = 1;
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    PSEL = 0;
    PENABLE = 0;
    PWRITE = 0;
    PADDR = 8'h00;
    PWDATA = 32'h00000000;
    TX_OCTET = 8'h5A;
    n_errors = 0;
    checked = 0;
    RST = 1;
    repeat (12) @(posedge CLK);
    RST <= 0;
    rdc(`DPM_REG_CTRL, 32'hFFFFFFFF, 32'h00000011, 0);
    rdc(`DPM_REG_IDLE, 32'hFFFFFFFF, 32'h000000FF, 0);
    rdc(`DPM_REG_ALLOC, 32'hFFFFFFFF, 32'h00000000, 0);
    rdc(8'h14, 32'hFFFFFFFF, 32'h00000000, 1); // unmapped place
    frames(25);
    for (i = 1; i < 24; i++) check("idle slot", 8'hFF, slot(i));
    check("d slot", 8'hA5, slot(24));
    for (i = 0; i < 24; i += 2) check("link bit", 1, fsf[i]);
    for (i = 3; i < 24; i += 4) check("align bit", 6'h0B >> (5 - i / 4) & 1, fsf[i]);
    check("rx idle", 1, rxi[2]);
    check("rx octet", 8'hF0, rxo[2]);
    check("rx d octet", 8'h0F, rxo[24]);
    wr(`DPM_REG_IDLE, 32'h00000000);
    rdc(`DPM_REG_IDLE, 32'h000000FF, 32'h0000007F, 0);
    wr(`DPM_REG_ALLOC, 32'h00000001);
    TX_OCTET <= 8'h00;
    frames(2);
    check("zero octet", 8'h01, slot(1));
    check("idle code", 8'h7F, slot(2));
    check("rx alloc idle", 0, rxi[1]);
    wr(`DPM_REG_CTRL, 32'h00000013);
    frames(2);
    check("clear octet", 8'h00, slot(1));
    wr(`DPM_REG_CTRL, 32'h00000015);
    frames(25);
    z = 0;
    for (i = 0; i < 24; i += 2) z += (fsf[i] == 1'b0);
    check("yellow zeros", 1, z >= 4 && z <= 8);
    wr(`DPM_REG_SIXMAP, 32'h00000008);
    rdc(`DPM_REG_STATUS, 32'h00000020, 32'h00000020, 0);
    wr(`DPM_REG_SIXMAP, 32'h00000001);
    rdc(`DPM_REG_STATUS, 32'h00000020, 32'h00000000, 0);
    wr(`DPM_REG_CTRL, 32'h00000014);
    frames(14);
    for (i = 1; i < 25; i++) check("bit two", 0, slot(i) & 8'h40);
    check("d4 f bits", 1, is_rot(fh[11:0], 12'h8DC));
    // d4, no yellow, every slot active with bit two zero: the guard
    // must break the run before YEL_FRAMES (4 here) frames pass
    wr(`DPM_REG_SIXMAP, 32'h00000000);
    wr(`DPM_REG_ALLOC, 32'h00FFFFFF);
    wr(`DPM_REG_CTRL, 32'h00000012);
    frames(2);
    z = 0;
    mx = 0;
    repeat (8) begin
      frames(1);
      b2 = 0;
      for (i = 1; i < 25; i++) b2 = b2 | ((slot(i) & 8'h40) != 0);
      z = b2 ? 0 : z + 1;
      if (z > mx) mx = z;
    end
    check("bit two run", 1, mx > 0 && mx < 4);
    complete_run;
  end
endmodule
